// file: inc/csr_core_regs.svh
// register offsets, flag positions and reset values of the core special registers
`ifndef CSR_CORE_REGS_SVH
`define CSR_CORE_REGS_SVH
`define CSR_OFS_IND0 8'h00
`define CSR_OFS_PTR0 8'h01
`define CSR_OFS_IND1 8'h02
`define CSR_OFS_P1LO 8'h03
`define CSR_OFS_P1HI 8'h04
`define CSR_OFS_ACCUM 8'h05
`define CSR_OFS_PCLOW 8'h06
`define CSR_OFS_TPLO 8'h07
`define CSR_OFS_TRHI 8'h08
`define CSR_OFS_TPHI 8'h09
`define CSR_OFS_FLAGS 8'h0a
`define CSR_OFS_IND2 8'h0c
`define CSR_OFS_P2LO 8'h0d
`define CSR_OFS_P2HI 8'h0e
`define CSR_SECTOR0 8'h00
`define CSR_BIT_CARRY 0
`define CSR_BIT_HALF 1
`define CSR_BIT_NULL 2
`define CSR_BIT_OVF 3
`define CSR_BIT_SLEEP 4
`define CSR_BIT_EXPIRY 5
`define CSR_BIT_CHAIN 6
`define CSR_BIT_SIGNED 7
`define CSR_FLAGS_RST 8'h00
`define CSR_PROT_MASK 8'h30
`define CSR_READ_ZERO 8'h00
`define CSR_BYTE_RST 8'h00
`endif

// file: inc/csr_core_pkg.sv
// types shared by the core special register block
package csr_core_pkg;
  // alu operation performed on the accumulator
  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR, ALU_RLC, ALU_RRC
  } csr_aluop_t;
  // data access from the execution logic
  typedef struct packed {
    logic valid; // access this cycle
    logic wr; // 1 write, 0 read
    logic ext; // full 16-bit address given
    logic [15:0] addr; // sector byte and location
    logic [7:0] wdata; // write data
  } csr_req_t;
  // access passed on to the sectored data memory
  typedef struct packed {
    logic req; // access this cycle
    logic we; // write strobe
    logic [15:0] addr; // sector byte and location
    logic [7:0] wdata; // write data
  } csr_mem_t;
endpackage : csr_core_pkg

// file: rtl/csr_core.sv
// core special registers: indirect ports, pointers, accumulator, table and condition flags
`timescale 1ns/1ns
`include "csr_core_regs.svh"
module csr_core #(
  parameter int PROG_W = 16 // program word width
) (
  input wire logic core_clk, // 20 MHz system clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire csr_core_pkg::csr_req_t req, // data access request
  output logic [7:0] rdData, // read data, one cycle after request
  output logic rdValid, // read data valid
  output csr_core_pkg::csr_mem_t memOut, // access to data memory
  input wire logic [7:0] memRdata, // memory read data, one cycle later
  input wire logic aluValid, // alu operation this cycle
  input wire csr_core_pkg::csr_aluop_t aluOp, // alu operation
  input wire logic [7:0] aluOperand, // second operand
  output logic [7:0] accum, // accumulator value
  output logic [7:0] flags, // condition flags value
  input wire logic [7:0] pcCurLow, // current program counter low byte
  output logic pcJump, // pulse: load pc low byte
  output logic [7:0] pcLowByte, // new pc low byte
  output logic dummyCycle, // pulse: dummy cycle inserted
  input wire logic tblRead, // pulse: table read request
  output logic progReq, // program memory fetch
  output logic [15:0] progAddr, // program memory address
  input wire logic [PROG_W-1:0] progData, // program word, one cycle later
  output logic [7:0] tblLow, // low table byte to destination
  output logic tblLowValid, // low table byte valid
  input wire logic watchdogClear, // watchdog clear instruction
  input wire logic sleepCmd, // sleep instruction
  input wire logic watchdogExpire // watchdog time-out
);
  // storage
  logic [7:0] ptr0_q, p1lo_q, p1hi_q, p2lo_q, p2hi_q; // memory pointers
  logic [7:0] accum_q, tpLo_q, tpHi_q, trHi_q; // accumulator and table registers
  logic [7:0] flags_q, flags_d; // condition flags
  logic [7:0] rdLocal_q; // captured local read value
  logic rdMem_q, rdValid_q; // read source and valid
  logic pcJump_q, dummy_q, tblPend_q, tblLowValid_q; // sequencing
  logic [7:0] pcLow_q, tblLow_q; // data outputs
  logic [7:0] localRd; // local read mux
  logic [7:0] aluRes; // alu result

  // address resolution
  wire [15:0] dirAddr = req.ext ? req.addr : {`CSR_SECTOR0, req.addr[7:0]};
  wire dirSec0 = dirAddr[15:8] == `CSR_SECTOR0;
  wire ind0 = dirSec0 && dirAddr[7:0] == `CSR_OFS_IND0;
  wire ind1 = dirSec0 && dirAddr[7:0] == `CSR_OFS_IND1;
  wire ind2 = dirSec0 && dirAddr[7:0] == `CSR_OFS_IND2;
  wire [15:0] effAddr = ind0 ? {`CSR_SECTOR0, ptr0_q} :
                        ind1 ? {p1hi_q, p1lo_q} :
                        ind2 ? {p2hi_q, p2lo_q} : dirAddr;
  wire effSec0 = effAddr[15:8] == `CSR_SECTOR0;
  wire [7:0] effLo = effAddr[7:0];
  wire effInd = effSec0 && (effLo == `CSR_OFS_IND0 || effLo == `CSR_OFS_IND1 || effLo == `CSR_OFS_IND2);
  wire localHit = effSec0 && effLo <= `CSR_OFS_P2HI && effLo != 8'h0b;
  wire localWr = req.valid && req.wr && localHit && !effInd;
  wire wrPtr0 = localWr && effLo == `CSR_OFS_PTR0;
  wire wrAccum = localWr && effLo == `CSR_OFS_ACCUM;
  wire wrPcLow = localWr && effLo == `CSR_OFS_PCLOW;
  wire wrFlags = localWr && effLo == `CSR_OFS_FLAGS;

  // non-local accesses go on to data memory; indirect targets never do
  assign memOut.req = req.valid && !localHit;
  assign memOut.we = req.wr;
  assign memOut.addr = effAddr;
  assign memOut.wdata = req.wdata;

  // local read mux, holes read zero
  always_comb begin
    unique case (effLo)
      `CSR_OFS_PTR0: localRd = ptr0_q;
      `CSR_OFS_P1LO: localRd = p1lo_q;
      `CSR_OFS_P1HI: localRd = p1hi_q;
      `CSR_OFS_ACCUM: localRd = accum_q;
      `CSR_OFS_PCLOW: localRd = pcCurLow;
      `CSR_OFS_TPLO: localRd = tpLo_q;
      `CSR_OFS_TRHI: localRd = trHi_q;
      `CSR_OFS_TPHI: localRd = tpHi_q;
      `CSR_OFS_FLAGS: localRd = flags_q;
      `CSR_OFS_P2LO: localRd = p2lo_q;
      `CSR_OFS_P2HI: localRd = p2hi_q;
      default: localRd = `CSR_READ_ZERO;
    endcase
  end

  // read capture
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdValid_q <= 1'b0;
      rdMem_q <= 1'b0;
      rdLocal_q <= `CSR_BYTE_RST;
    end else begin
      rdValid_q <= req.valid && !req.wr;
      rdMem_q <= !localHit;
      rdLocal_q <= localRd;
    end
  end
  assign rdValid = rdValid_q;
  assign rdData = rdMem_q ? memRdata : rdLocal_q;

  // pointer and table pointer registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr0_q <= `CSR_BYTE_RST;
      p1lo_q <= `CSR_BYTE_RST;
      p1hi_q <= `CSR_BYTE_RST;
      p2lo_q <= `CSR_BYTE_RST;
      p2hi_q <= `CSR_BYTE_RST;
      tpLo_q <= `CSR_BYTE_RST;
      tpHi_q <= `CSR_BYTE_RST;
    end else if (localWr) begin
      if (wrPtr0) ptr0_q <= req.wdata;
      if (effLo == `CSR_OFS_P1LO) p1lo_q <= req.wdata;
      if (effLo == `CSR_OFS_P1HI) p1hi_q <= req.wdata;
      if (effLo == `CSR_OFS_P2LO) p2lo_q <= req.wdata;
      if (effLo == `CSR_OFS_P2HI) p2hi_q <= req.wdata;
      if (effLo == `CSR_OFS_TPLO) tpLo_q <= req.wdata;
      if (effLo == `CSR_OFS_TPHI) tpHi_q <= req.wdata;
    end
  end

  // alu arithmetic terms; subtraction adds the inverted operand
  wire isSub = aluOp == csr_core_pkg::ALU_SUB || aluOp == csr_core_pkg::ALU_SBC;
  wire isArith = isSub || aluOp == csr_core_pkg::ALU_ADD || aluOp == csr_core_pkg::ALU_ADC;
  wire useCarry = aluOp == csr_core_pkg::ALU_ADC || aluOp == csr_core_pkg::ALU_SBC;
  wire [7:0] opB = isSub ? ~aluOperand : aluOperand;
  wire carryIn = useCarry ? flags_q[`CSR_BIT_CARRY] : isSub;
  wire [8:0] sum = {1'b0, accum_q} + {1'b0, opB} + {8'h00, carryIn};
  wire [4:0] nib = {1'b0, accum_q[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
  wire [7:0] low7 = {1'b0, accum_q[6:0]} + {1'b0, opB[6:0]} + {7'h00, carryIn};
  wire ovf = low7[7] ^ sum[8];
  wire resNull = aluRes == 8'h00;

  // alu result select
  always_comb begin
    unique case (aluOp)
      csr_core_pkg::ALU_ADD, csr_core_pkg::ALU_ADC,
      csr_core_pkg::ALU_SUB, csr_core_pkg::ALU_SBC: aluRes = sum[7:0];
      csr_core_pkg::ALU_AND: aluRes = accum_q & aluOperand;
      csr_core_pkg::ALU_OR: aluRes = accum_q | aluOperand;
      csr_core_pkg::ALU_XOR: aluRes = accum_q ^ aluOperand;
      csr_core_pkg::ALU_RLC: aluRes = {accum_q[6:0], flags_q[`CSR_BIT_CARRY]};
      csr_core_pkg::ALU_RRC: aluRes = {flags_q[`CSR_BIT_CARRY], accum_q[7:1]};
      default: aluRes = 8'h00; // undefined operation codes give zero
    endcase
  end

  // accumulator: alu result wins over a data write in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) accum_q <= `CSR_BYTE_RST;
    else if (aluValid) accum_q <= aluRes;
    else if (wrAccum) accum_q <= req.wdata;
  end
  assign accum = accum_q;

  // next flags: data write, then alu update, then system events
  always_comb begin
    flags_d = flags_q;
    if (wrFlags && !aluValid) flags_d = (req.wdata & ~`CSR_PROT_MASK) | (flags_q & `CSR_PROT_MASK);
    if (aluValid) begin
      if (isArith) begin
        flags_d[`CSR_BIT_CARRY] = sum[8];
        flags_d[`CSR_BIT_HALF] = nib[4];
        flags_d[`CSR_BIT_NULL] = resNull;
        flags_d[`CSR_BIT_OVF] = ovf;
        flags_d[`CSR_BIT_SIGNED] = ovf ^ aluRes[7];
        if (aluOp == csr_core_pkg::ALU_SUB) flags_d[`CSR_BIT_CHAIN] = resNull;
        if (aluOp == csr_core_pkg::ALU_SBC) flags_d[`CSR_BIT_CHAIN] = flags_q[`CSR_BIT_CHAIN] & resNull;
      end else if (aluOp == csr_core_pkg::ALU_RLC) begin
        flags_d[`CSR_BIT_CARRY] = accum_q[7];
      end else if (aluOp == csr_core_pkg::ALU_RRC) begin
        flags_d[`CSR_BIT_CARRY] = accum_q[0];
      end else begin
        flags_d[`CSR_BIT_NULL] = resNull;
      end
    end
    if (watchdogClear) begin
      flags_d[`CSR_BIT_EXPIRY] = 1'b0;
      flags_d[`CSR_BIT_SLEEP] = 1'b0;
    end
    if (sleepCmd) begin
      flags_d[`CSR_BIT_EXPIRY] = 1'b0;
      flags_d[`CSR_BIT_SLEEP] = 1'b1;
    end
    if (watchdogExpire) flags_d[`CSR_BIT_EXPIRY] = 1'b1;
  end

  // flags load flags_d on every clock, not only with an accumulator write; nothing here pushes them anywhere
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) flags_q <= `CSR_FLAGS_RST;
    else flags_q <= flags_d;
  end
  assign flags = flags_q;

  // pc low byte write: jump within the page plus one dummy cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pcJump_q <= 1'b0;
      dummy_q <= 1'b0;
      pcLow_q <= `CSR_BYTE_RST;
    end else begin
      pcJump_q <= wrPcLow;
      dummy_q <= wrPcLow;
      if (wrPcLow) pcLow_q <= req.wdata;
    end
  end
  assign pcJump = pcJump_q;
  assign dummyCycle = dummy_q;
  assign pcLowByte = pcLow_q;

  // table read: fetch at the table pointers, split the word
  assign progReq = tblRead;
  assign progAddr = {tpHi_q, tpLo_q};
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tblPend_q <= 1'b0;
      tblLowValid_q <= 1'b0;
      trHi_q <= `CSR_BYTE_RST;
      tblLow_q <= `CSR_BYTE_RST;
    end else begin
      tblPend_q <= tblRead;
      tblLowValid_q <= tblPend_q;
      if (tblPend_q) begin
        trHi_q <= progData[15:8];
        tblLow_q <= progData[7:0];
      end else if (localWr && effLo == `CSR_OFS_TRHI) begin
        trHi_q <= req.wdata;
      end
    end
  end
  assign tblLow = tblLow_q;
  assign tblLowValid = tblLowValid_q;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // a further write right behind the first keeps the jump pulse up
  sequence jumpSeq;
    pcJump && dummyCycle ##1 ($past(wrPcLow) || (!pcJump && !dummyCycle));
  endsequence
  sequence tblSeq;
    progAddr == {tpHi_q, tpLo_q} ##2 tblLowValid;
  endsequence
  chk_ind_read_zero: assert property (req.valid && !req.wr && effInd |=> rdValid && rdData == 8'h00)
    else $error("indirect port read not zero");
  chk_ind0_sector: assert property (req.valid && ind0 && memOut.req |-> memOut.addr[15:8] == 8'h00)
    else $error("port zero left sector zero");
  chk_ind1_target: assert property (req.valid && ind1 && memOut.req |-> memOut.addr == {p1hi_q, p1lo_q})
    else $error("port one target wrong");
  chk_pc_jump: assert property (req.valid && req.wr && !ind0 && !ind1 && !ind2 && dirAddr == {`CSR_SECTOR0, `CSR_OFS_PCLOW}
    |=> jumpSeq)
    else $error("pc low write did not jump once");
  chk_table_read: assert property (tblRead && !tblPend_q |-> tblSeq)
    else $error("table read sequence wrong");
  chk_table_data: assert property (tblPend_q
    |=> tblLow == $past(progData[7:0]) && trHi_q == $past(progData[15:8]))
    else $error("table bytes not captured");
  chk_ptr_write: assert property (wrPtr0 |=> ptr0_q == $past(req.wdata))
    else $error("pointer zero not stored");
  chk_ind2_target: assert property (req.valid && ind2 && !localHit |-> memOut.req && memOut.addr == {p2hi_q, p2lo_q})
    else $error("port two target wrong");
  chk_flag_protect: assert property (!watchdogClear && !sleepCmd && !watchdogExpire
    |=> $stable(flags[5:4]))
    else $error("protected flags changed");
  chk_flag_write: assert property (wrFlags && !aluValid && !watchdogClear && !sleepCmd && !watchdogExpire
    |=> flags == (($past(req.wdata) & ~`CSR_PROT_MASK) | ($past(flags_q) & `CSR_PROT_MASK)))
    else $error("flag write wrong");
  chk_expiry_set: assert property (watchdogExpire |=> flags[5])
    else $error("expiry flag not set");
  chk_sleep_set: assert property (sleepCmd && !watchdogExpire |=> flags[4] && !flags[5])
    else $error("sleep flags wrong");
  chk_null_flag: assert property (aluValid && isArith |=> flags[2] == (accum == 8'h00))
    else $error("null flag wrong");
  chk_signed_flag: assert property (aluValid && isArith |=> flags[7] == (flags[3] ^ accum[7]))
    else $error("signed compare flag wrong");
  chk_chain_flag: assert property (aluValid && aluOp == csr_core_pkg::ALU_SBC
    |=> flags[6] == ($past(flags_q[6]) && flags[2]))
    else $error("chained null flag wrong");
endmodule : csr_core

// file: verif/csr_far_model.sv
// data and program memory model on the far side of the core special registers
`timescale 1ns/1ns
module csr_far_model (
  input wire logic core_clk, // system clock
  input wire csr_core_pkg::csr_mem_t memOut, // data access from the block
  output logic [7:0] memRdata, // data read, one cycle later
  input wire logic progReq, // program fetch
  input wire logic [15:0] progAddr, // program address
  output logic [15:0] progData // program word, one cycle later
);
  logic [7:0] mem [0:511]; // sectors zero and one
  // marker fill so untouched places are recognisable
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 8'hee;
    end
    memRdata = 8'h00;
    progData = 16'h0000;
  end
  // answers one cycle later; idle lines toggle so stale data never passes
  always @(posedge core_clk) begin
    if (memOut.req && memOut.we) begin
      mem[{memOut.addr[8], memOut.addr[7:0]}] <= memOut.wdata;
    end
    memRdata <= (memOut.req && !memOut.we) ? mem[{memOut.addr[8], memOut.addr[7:0]}] : ~memRdata;
    progData <= progReq ? {~progAddr[7:0], progAddr[15:8]} : ~progData;
  end
endmodule : csr_far_model

// file: verif/tb_top.sv
// self-checking bench of the core special registers
`timescale 1ns/1ns
`include "csr_core_regs.svh"
module tb_top;
  logic core_clk, arst_n; // clock, reset active low
  csr_core_pkg::csr_req_t req; // data access
  logic [7:0] rdData, memRdata, aluOperand, accum, flags; // data bytes
  logic rdValid, aluValid, pcJump, dummyCycle, tblRead, progReq, tblLowValid; // strobes
  csr_core_pkg::csr_mem_t memOut; // memory access
  csr_core_pkg::csr_aluop_t aluOp; // alu operation
  logic [7:0] pcCurLow, pcLowByte, tblLow; // pc and table bytes
  logic [15:0] progAddr, progData; // program side
  logic watchdogClear, sleepCmd, watchdogExpire; // system events
  int errTotal; // mismatches
  int nCompared; // comparisons
  // block under test and its far side
  csr_core i_csr_core (.core_clk, .arst_n, .req, .rdData, .rdValid, .memOut, .memRdata, .aluValid, .aluOp,
    .aluOperand, .accum, .flags, .pcCurLow, .pcJump, .pcLowByte, .dummyCycle, .tblRead, .progReq, .progAddr,
    .progData, .tblLow, .tblLowValid, .watchdogClear, .sleepCmd, .watchdogExpire);
  csr_far_model i_csr_far_model (.core_clk, .memOut, .memRdata, .progReq, .progAddr, .progData);
  // 50 ns clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one data write, taken at the second edge
  task automatic wr(input logic [15:0] a, input logic x, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{1'b1, 1'b1, x, a, d};
    @(posedge core_clk);
    req <= '0;
    #1;
  endtask : wr
  // one data read, answer checked in the cycle after the request
  task automatic rd(input logic [15:0] a, input logic x, input logic [7:0] e);
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, x, a, 8'h00};
    @(posedge core_clk);
    req <= '0;
    #1;
    chk({7'h00, rdValid, rdData}, {8'h01, e});
  endtask : rd
  // one-cycle pulse: 0 clear, 1 sleep, 2 expiry
  task automatic pulse(input int k);
    @(posedge core_clk);
    {watchdogExpire, sleepCmd, watchdogClear} <= 3'b001 << k;
    @(posedge core_clk);
    {watchdogExpire, sleepCmd, watchdogClear} <= 3'b000;
    #1;
  endtask : pulse
  // values straight after reset
  task automatic t_reset;
    #1;
    chk({accum, flags}, 16'h0000);
    rd({8'h00, `CSR_OFS_FLAGS}, 1'b0, 8'h00);
  endtask : t_reset
  // indirect ports, pointers, sectors
  task automatic t_ind;
    wr({8'h00, `CSR_OFS_P1LO}, 1'b0, 8'h40);
    wr({8'h00, `CSR_OFS_P1HI}, 1'b0, 8'h01);
    wr({8'h00, `CSR_OFS_IND1}, 1'b0, 8'ha5);
    rd(16'h0140, 1'b1, 8'ha5);
    rd({8'h00, `CSR_OFS_P1LO}, 1'b0, 8'h40);
    wr({8'h00, `CSR_OFS_PTR0}, 1'b0, 8'h80);
    wr({8'h00, `CSR_OFS_IND0}, 1'b0, 8'h3c);
    rd(16'h0180, 1'b1, 8'hee);
    rd(16'h0080, 1'b1, 8'h3c);
    wr({8'h00, `CSR_OFS_P2LO}, 1'b0, 8'h80);
    wr({8'h00, `CSR_OFS_P2HI}, 1'b0, 8'h00);
    rd({8'h00, `CSR_OFS_IND2}, 1'b0, 8'h3c);
    wr({8'h00, `CSR_OFS_PTR0}, 1'b0, 8'h02);
    wr({8'h00, `CSR_OFS_IND0}, 1'b0, 8'h77);
    rd({8'h00, `CSR_OFS_IND0}, 1'b0, 8'h00);
    rd({8'h00, `CSR_OFS_IND1}, 1'b0, 8'ha5);
  endtask : t_ind
  // every alu operation with its flag outcome
  task automatic t_alu;
    logic [3:0] seq [9] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h7, 4'h1};
    logic [7:0] opd [9] = '{8'h01, 8'h80, 8'h01, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'hf1};
    logic [7:0] acc [9] = '{8'h80, 8'h00, 8'hff, 8'h00, 8'h00, 8'h0f, 8'h07, 8'h0f, 8'h00};
    logic [7:0] flg [9] = '{8'h0a, 8'h47, 8'h80, 8'h84, 8'h84, 8'h80, 8'h81, 8'h80, 8'h07};
    wr({8'h00, `CSR_OFS_ACCUM}, 1'b0, 8'h7f);
    for (int i = 0; i < 9; i++) begin
      @(posedge core_clk);
      aluValid <= 1'b1;
      aluOp <= csr_core_pkg::csr_aluop_t'(seq[i]);
      aluOperand <= opd[i];
      @(posedge core_clk);
      aluValid <= 1'b0;
      #1;
      chk({accum, flags}, {acc[i], flg[i]});
    end
    rd({8'h00, `CSR_OFS_ACCUM}, 1'b0, 8'h00);
  endtask : t_alu
  // protected flags against writes and events
  task automatic t_flags;
    wr({8'h00, `CSR_OFS_FLAGS}, 1'b0, 8'hff);
    chk({8'h00, flags}, 16'h00cf);
    pulse(1);
    chk({8'h00, flags}, 16'h00df);
    pulse(2);
    chk({8'h00, flags}, 16'h00ff);
    wr({8'h00, `CSR_OFS_FLAGS}, 1'b0, 8'h00);
    chk({8'h00, flags}, 16'h0030);
    pulse(0);
    chk({8'h00, flags}, 16'h0000);
    pulse(2);
    pulse(1);
    rd({8'h00, `CSR_OFS_FLAGS}, 1'b0, 8'h10);
  endtask : t_flags
  // pc low write jumps with one dummy cycle
  task automatic t_pc;
    wr({8'h00, `CSR_OFS_PCLOW}, 1'b0, 8'h5a);
    chk({6'h00, pcJump, dummyCycle, pcLowByte}, 16'h035a);
    @(posedge core_clk);
    #1;
    chk({14'h0000, pcJump, dummyCycle}, 16'h0000);
    rd({8'h00, `CSR_OFS_PCLOW}, 1'b0, 8'h3c);
  endtask : t_pc
  // table read through both pointers
  task automatic t_tbl;
    wr({8'h00, `CSR_OFS_TPLO}, 1'b0, 8'h34);
    wr({8'h00, `CSR_OFS_TPHI}, 1'b0, 8'h12);
    @(posedge core_clk);
    tblRead <= 1'b1;
    #1;
    chk(progAddr, 16'h1234);
    chk({15'h0000, progReq}, 16'h0001);
    @(posedge core_clk);
    tblRead <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({7'h00, tblLowValid, tblLow}, 16'h0112);
    rd({8'h00, `CSR_OFS_TRHI}, 1'b0, 8'hcb);
  endtask : t_tbl
  // verdict and end of run
  task automatic completeRun;
    $display("compared %0d mismatched %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : completeRun
  // hang guard, far beyond the hundred or so cycles needed
  initial begin
    #(50 * 3000);
    errTotal++;
    completeRun();
  end
  // main sequence
  initial begin
    {arst_n, aluValid, tblRead, watchdogClear, sleepCmd, watchdogExpire} = '0;
    req = '0;
    aluOp = csr_core_pkg::ALU_ADD;
    aluOperand = 8'h00;
    pcCurLow = 8'h3c;
    errTotal = 0;
    nCompared = 0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    $display("test reset done");
    t_ind();
    $display("test indirect done");
    t_alu();
    $display("test alu done");
    t_flags();
    $display("test flags done");
    t_pc();
    $display("test pc done");
    t_tbl();
    $display("test table done");
    completeRun();
  end
endmodule : tb_top
